// ==== verilog/dsprd_pkg.sv ====
// Constants for the dual serial channel and printer port register decode.
// Assumes a host that presents address, selects and strobes synchronously.
package dsprd_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int NUM_CHAN = 2;

  // Serial channel offsets, divisor set
  localparam logic [2:0] ADDR_DIV_LOW   = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH  = 3'h1;
  // Serial channel offsets, general set
  localparam logic [2:0] ADDR_DATA      = 3'h0;
  localparam logic [2:0] ADDR_INT       = 3'h1;
  localparam logic [2:0] ADDR_FIFO      = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTL  = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STAT = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STAT= 3'h6;
  localparam logic [2:0] ADDR_SCRATCH   = 3'h7;

  // Printer offsets, top address bit ignored
  localparam logic [1:0] PADDR_DATA     = 2'h0;
  localparam logic [1:0] PADDR_STAT_DIR = 2'h1;
  localparam logic [1:0] PADDR_CMD_CTL  = 2'h2;

  // Field positions and codes
  localparam int LINE_CTL_DIV_BIT = 7;
  localparam int PRN_CTL_DIR_BIT  = 5;
  localparam logic [7:0] DIR_CODE_INPUT  = 8'haa;
  localparam logic [7:0] DIR_CODE_OUTPUT = 8'h55;

  // Reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] IDLE_BYTE  = 8'h00;
endpackage

// ==== verilog/dsprd_reg_if.sv ====
// Decoded register access path from the top decode to one register set.
// Assumes strobes are one clock wide and synchronous to the system clock.
`timescale 1ns/1ps
interface dsprd_reg_if;
  logic       sel;
  logic       wr;
  logic       rd;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport decode (output sel, output wr, output rd, output addr,
                  output wdata, input rdata);
  modport regs   (input sel, input wr, input rd, input addr,
                  input wdata, output rdata);
endinterface

// ==== verilog/dsprd_chan.sv ====
// Register set of one serial channel: general set and divisor set.
// Assumes the decode drives sel from the channel's active-low select.
`timescale 1ns/1ps
module dsprd_chan (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  dsprd_reg_if.regs       bus,
  input  wire logic [7:0] i_rx_data,
  input  wire logic [7:0] i_int_status,
  input  wire logic [7:0] i_line_status,
  input  wire logic [7:0] i_modem_status,
  output logic [15:0]     o_divisor,
  output logic [7:0]      o_line_control,
  output logic [7:0]      o_int_enable,
  output logic [7:0]      o_fifo_control,
  output logic [7:0]      o_modem_control,
  output logic [7:0]      o_tx_data,
  output logic            o_tx_load,
  output logic            o_rx_read
);
  logic       div_access;
  logic       gen_wr;
  logic [7:0] scratch_r;

  // Divisor access bit steers both reads and writes
  assign div_access = o_line_control[dsprd_pkg::LINE_CTL_DIV_BIT];
  assign gen_wr     = bus.sel & bus.wr;

  // Holding-register side effects only in the general set
  assign o_tx_load = gen_wr & ~div_access
                     & (bus.addr == dsprd_pkg::ADDR_DATA);
  assign o_rx_read = bus.sel & bus.rd & ~div_access
                     & (bus.addr == dsprd_pkg::ADDR_DATA);

  // Divisor latch bytes
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_divisor <= {dsprd_pkg::RST_BYTE, dsprd_pkg::RST_BYTE};
    end else if (gen_wr && div_access) begin
      if (bus.addr == dsprd_pkg::ADDR_DIV_LOW) begin
        o_divisor[7:0] <= bus.wdata;
      end
      if (bus.addr == dsprd_pkg::ADDR_DIV_HIGH) begin
        o_divisor[15:8] <= bus.wdata;
      end
    end
  end

  // General set writable registers; line control stays reachable always
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_line_control  <= dsprd_pkg::RST_BYTE;
      o_int_enable    <= dsprd_pkg::RST_BYTE;
      o_fifo_control  <= dsprd_pkg::RST_BYTE;
      o_modem_control <= dsprd_pkg::RST_BYTE;
      o_tx_data       <= dsprd_pkg::RST_BYTE;
      scratch_r       <= dsprd_pkg::RST_BYTE;
    end else if (gen_wr) begin
      unique case (bus.addr)
        dsprd_pkg::ADDR_DATA: begin
          if (!div_access) o_tx_data <= bus.wdata;
        end
        dsprd_pkg::ADDR_INT: begin
          if (!div_access) o_int_enable <= bus.wdata;
        end
        dsprd_pkg::ADDR_FIFO:      o_fifo_control  <= bus.wdata;
        dsprd_pkg::ADDR_LINE_CTL:  o_line_control  <= bus.wdata;
        dsprd_pkg::ADDR_MODEM_CTL: o_modem_control <= bus.wdata;
        dsprd_pkg::ADDR_SCRATCH:   scratch_r       <= bus.wdata;
        default: ; // Status offsets are read only
      endcase
    end
  end

  // Read mux; divisor set overlays the two lowest offsets
  always_comb begin
    bus.rdata = dsprd_pkg::IDLE_BYTE;
    unique case (bus.addr)
      dsprd_pkg::ADDR_DATA:
        bus.rdata = div_access ? o_divisor[7:0] : i_rx_data;
      dsprd_pkg::ADDR_INT:
        bus.rdata = div_access ? o_divisor[15:8] : i_int_status;
      dsprd_pkg::ADDR_FIFO:       bus.rdata = i_int_status;
      dsprd_pkg::ADDR_LINE_CTL:   bus.rdata = o_line_control;
      dsprd_pkg::ADDR_MODEM_CTL:  bus.rdata = o_modem_control;
      dsprd_pkg::ADDR_LINE_STAT:  bus.rdata = i_line_status;
      dsprd_pkg::ADDR_MODEM_STAT: bus.rdata = i_modem_status;
      dsprd_pkg::ADDR_SCRATCH:    bus.rdata = scratch_r;
    endcase
  end
endmodule // dsprd_chan

// ==== verilog/dsprd_prn.sv ====
// Printer port register set: data port, status, direction and control.
// Assumes the decode drives sel from the active-low printer select.
`timescale 1ns/1ps
module dsprd_prn (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  dsprd_reg_if.regs       bus,
  input  wire logic       i_bidirectional_enable_pin,
  input  wire logic [7:0] i_port_in,
  input  wire logic [7:0] i_printer_status,
  output logic [7:0]      o_port_out,
  output logic            o_port_oe,
  output logic [7:0]      o_printer_control
);
  logic [1:0] paddr;
  logic       wr_hit;
  logic       dir_reg_input_r;
  logic       dir_input;

  // Top address bit plays no part in the printer set
  assign paddr  = bus.addr[1:0];
  assign wr_hit = bus.sel & bus.wr;

  // Pin picks the direction source; control bit wins when enabled
  assign dir_input = i_bidirectional_enable_pin
                     ? o_printer_control[dsprd_pkg::PRN_CTL_DIR_BIT]
                     : dir_reg_input_r;
  assign o_port_oe = ~dir_input;

  // Data port latch and control register
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_port_out        <= dsprd_pkg::RST_BYTE;
      o_printer_control <= dsprd_pkg::RST_BYTE;
    end else if (wr_hit) begin
      if (paddr == dsprd_pkg::PADDR_DATA) o_port_out <= bus.wdata;
      if (paddr == dsprd_pkg::PADDR_CMD_CTL) begin
        o_printer_control <= bus.wdata;
      end
    end
  end

  // Direction register keeps its state unless one of the two codes lands
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      dir_reg_input_r <= 1'b0;
    end else if (wr_hit && paddr == dsprd_pkg::PADDR_STAT_DIR) begin
      if (bus.wdata == dsprd_pkg::DIR_CODE_INPUT) begin
        dir_reg_input_r <= 1'b1;
      end else if (bus.wdata == dsprd_pkg::DIR_CODE_OUTPUT) begin
        dir_reg_input_r <= 1'b0;
      end
    end
  end

  // Port reads return the pins when the port faces inward
  always_comb begin
    bus.rdata = dsprd_pkg::IDLE_BYTE;
    unique case (paddr)
      dsprd_pkg::PADDR_DATA:
        bus.rdata = dir_input ? i_port_in : o_port_out;
      dsprd_pkg::PADDR_STAT_DIR: bus.rdata = i_printer_status;
      dsprd_pkg::PADDR_CMD_CTL:  bus.rdata = o_printer_control;
      default:                   bus.rdata = dsprd_pkg::IDLE_BYTE;
    endcase
  end
endmodule // dsprd_prn

// ==== verilog/dsprd_top.sv ====
// Host register decode for two serial channels and a printer port.
// Assumes host address, selects and strobes are synchronous to i_sys_clk
// and that read and write strobes are one cycle wide.
`timescale 1ns/1ps
module dsprd_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic [2:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [1:0]  i_chan_select_n,
  input  wire logic        i_printer_select_n,
  output logic [7:0]       o_rdata,
  output logic             o_rdata_oe,
  // Serial channel side, index 0 is channel A
  input  wire logic [1:0][7:0] i_rx_data,
  input  wire logic [1:0][7:0] i_int_status,
  input  wire logic [1:0][7:0] i_line_status,
  input  wire logic [1:0][7:0] i_modem_status,
  output logic [1:0][15:0] o_divisor,
  output logic [1:0][7:0]  o_line_control,
  output logic [1:0][7:0]  o_int_enable,
  output logic [1:0][7:0]  o_fifo_control,
  output logic [1:0][7:0]  o_modem_control,
  output logic [1:0][7:0]  o_tx_data,
  output logic [1:0]       o_tx_load,
  output logic [1:0]       o_rx_read,
  // Printer side
  input  wire logic        i_bidirectional_enable_pin,
  input  wire logic [7:0]  i_port_in,
  input  wire logic [7:0]  i_printer_status,
  output logic [7:0]       o_port_out,
  output logic             o_port_oe,
  output logic [7:0]       o_printer_control
);
  dsprd_reg_if ch_bus [dsprd_pkg::NUM_CHAN] ();
  dsprd_reg_if prn_bus ();

  logic [1:0] chan_sel;
  logic [7:0] ch_rdata [dsprd_pkg::NUM_CHAN];
  logic       prn_sel;
  logic       any_sel;
  logic       rd_hit;
  logic [7:0] rdata_nxt;

  // Active-low selects become per-set enables
  assign chan_sel = ~i_chan_select_n;
  assign prn_sel  = ~i_printer_select_n;
  assign any_sel  = (|chan_sel) | prn_sel;
  assign rd_hit   = i_rd & any_sel;

  // Fan the host bus out to both channels
  for (genvar c = 0; c < dsprd_pkg::NUM_CHAN; c++) begin : g_chan
    assign ch_bus[c].sel   = chan_sel[c];
    assign ch_bus[c].wr    = i_wr;
    assign ch_bus[c].rd    = i_rd;
    assign ch_bus[c].addr  = i_addr;
    assign ch_bus[c].wdata = i_wdata;
    assign ch_rdata[c]     = ch_bus[c].rdata;

    dsprd_chan u_chan (
      .i_sys_clk       (i_sys_clk),
      .i_reset         (i_reset),
      .bus             (ch_bus[c]),
      .i_rx_data       (i_rx_data[c]),
      .i_int_status    (i_int_status[c]),
      .i_line_status   (i_line_status[c]),
      .i_modem_status  (i_modem_status[c]),
      .o_divisor       (o_divisor[c]),
      .o_line_control  (o_line_control[c]),
      .o_int_enable    (o_int_enable[c]),
      .o_fifo_control  (o_fifo_control[c]),
      .o_modem_control (o_modem_control[c]),
      .o_tx_data       (o_tx_data[c]),
      .o_tx_load       (o_tx_load[c]),
      .o_rx_read       (o_rx_read[c])
    );
  end

  // Printer set sees the same bus under its own select
  assign prn_bus.sel   = prn_sel;
  assign prn_bus.wr    = i_wr;
  assign prn_bus.rd    = i_rd;
  assign prn_bus.addr  = i_addr;
  assign prn_bus.wdata = i_wdata;

  dsprd_prn u_prn (
    .i_sys_clk                  (i_sys_clk),
    .i_reset                    (i_reset),
    .bus                        (prn_bus),
    .i_bidirectional_enable_pin (i_bidirectional_enable_pin),
    .i_port_in                  (i_port_in),
    .i_printer_status           (i_printer_status),
    .o_port_out                 (o_port_out),
    .o_port_oe                  (o_port_oe),
    .o_printer_control          (o_printer_control)
  );

  // Read source; channel A over B over printer if the host overlaps selects
  always_comb begin
    rdata_nxt = dsprd_pkg::IDLE_BYTE;
    if (chan_sel[0]) begin
      rdata_nxt = ch_rdata[0];
    end else if (chan_sel[1]) begin
      rdata_nxt = ch_rdata[1];
    end else if (prn_sel) begin
      rdata_nxt = prn_bus.rdata;
    end
  end

  // Read data is captured so the bus sees a clean registered value
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= dsprd_pkg::IDLE_BYTE;
    end else if (rd_hit) begin
      o_rdata <= rdata_nxt;
    end
  end

  // Bus drive lasts one cycle per read, only when a select was low
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata_oe <= 1'b0;
    end else begin
      o_rdata_oe <= rd_hit;
    end
  end

  // Checks on the decode, all in the system clock domain
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence s_div_wr(logic [2:0] a);
    i_wr && !i_chan_select_n[0] && (i_addr == a)
    && o_line_control[0][dsprd_pkg::LINE_CTL_DIV_BIT];
  endsequence

  sequence s_ctl_wr;
    i_wr && !i_printer_select_n && i_chan_select_n == 2'b11
    && i_addr[1:0] == dsprd_pkg::PADDR_CMD_CTL;
  endsequence

  sequence s_ctl_rd;
    i_rd && !i_printer_select_n && i_chan_select_n == 2'b11
    && i_addr[1:0] == dsprd_pkg::PADDR_CMD_CTL && !i_wr;
  endsequence

  property p_div_low;
    s_div_wr(dsprd_pkg::ADDR_DIV_LOW) |=> o_divisor[0][7:0] == $past(i_wdata);
  endproperty
  a_div_low: assert property (p_div_low)
    else $error("divisor low byte not written");

  property p_div_high;
    s_div_wr(dsprd_pkg::ADDR_DIV_HIGH)
      |=> o_divisor[0][15:8] == $past(i_wdata);
  endproperty
  a_div_high: assert property (p_div_high)
    else $error("divisor high byte not written");

  property p_div_hides_tx;
    i_wr && o_line_control[0][dsprd_pkg::LINE_CTL_DIV_BIT]
      |-> !o_tx_load[0];
  endproperty
  a_div_hides_tx: assert property (p_div_hides_tx)
    else $error("transmit load while divisor access set");

  property p_gen_needs_sel;
    o_tx_load[0] || o_rx_read[0] |-> !i_chan_select_n[0];
  endproperty
  a_gen_needs_sel: assert property (p_gen_needs_sel)
    else $error("general set reached without select");

  property p_rx_read_data;
    i_rd && i_chan_select_n == 2'b10 && i_addr == dsprd_pkg::ADDR_DATA
    && !o_line_control[0][dsprd_pkg::LINE_CTL_DIV_BIT]
      |=> o_rdata_oe && o_rdata == $past(i_rx_data[0]);
  endproperty
  a_rx_read_data: assert property (p_rx_read_data)
    else $error("receive data not returned");

  property p_no_sel_quiet;
    i_chan_select_n == 2'b11 && i_printer_select_n
      |=> !o_rdata_oe && $stable(o_divisor) && $stable(o_port_out)
          && $stable(o_printer_control);
  endproperty
  a_no_sel_quiet: assert property (p_no_sel_quiet)
    else $error("activity without any select");

  property p_ctl_readback;
    s_ctl_wr ##1 !i_wr ##1 s_ctl_rd |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_ctl_readback: assert property (p_ctl_readback)
    else $error("control register readback wrong");

  property p_prn_needs_sel;
    i_wr && i_printer_select_n |=> $stable(o_printer_control);
  endproperty
  a_prn_needs_sel: assert property (p_prn_needs_sel)
    else $error("printer register changed without select");

  property p_dir_pin;
    i_bidirectional_enable_pin
      |-> o_port_oe == !o_printer_control[dsprd_pkg::PRN_CTL_DIR_BIT];
  endproperty
  a_dir_pin: assert property (p_dir_pin)
    else $error("port direction ignores control bit");

  // Channel B divisor write, same shape as channel A
  sequence s_chb_div_wr(logic [2:0] a);
    i_wr && !i_chan_select_n[1] && (i_addr == a)
    && o_line_control[1][dsprd_pkg::LINE_CTL_DIV_BIT];
  endsequence

  // Direction code write while the pin leaves the register in charge
  sequence s_dir_wr(logic [7:0] code);
    i_wr && !i_printer_select_n && !i_bidirectional_enable_pin
    && i_addr[1:0] == dsprd_pkg::PADDR_STAT_DIR && i_wdata == code;
  endsequence

  property p_div_low_b;
    s_chb_div_wr(dsprd_pkg::ADDR_DIV_LOW)
      |=> o_divisor[1][7:0] == $past(i_wdata);
  endproperty
  a_div_low_b: assert property (p_div_low_b)
    else $error("channel B divisor low byte not written");

  property p_div_high_b;
    s_chb_div_wr(dsprd_pkg::ADDR_DIV_HIGH)
      |=> o_divisor[1][15:8] == $past(i_wdata);
  endproperty
  a_div_high_b: assert property (p_div_high_b)
    else $error("channel B divisor high byte not written");

  property p_div_keeps_tx;
    s_div_wr(dsprd_pkg::ADDR_DATA)
      |=> $stable(o_tx_data[0]);
  endproperty
  a_div_keeps_tx: assert property (p_div_keeps_tx)
    else $error("transmit byte changed under divisor access");

  property p_tx_write;
    i_wr && !i_chan_select_n[0] && i_addr == dsprd_pkg::ADDR_DATA
    && !o_line_control[0][dsprd_pkg::LINE_CTL_DIV_BIT]
      |-> o_tx_load[0] ##1 o_tx_data[0] == $past(i_wdata);
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("transmit byte not loaded");

  property p_ie_write;
    i_wr && !i_chan_select_n[0] && i_addr == dsprd_pkg::ADDR_INT
    && !o_line_control[0][dsprd_pkg::LINE_CTL_DIV_BIT]
      |=> o_int_enable[0] == $past(i_wdata);
  endproperty
  a_ie_write: assert property (p_ie_write)
    else $error("interrupt enable not written");

  property p_isr_read;
    i_rd && i_chan_select_n == 2'b10 && i_addr == dsprd_pkg::ADDR_INT
    && !o_line_control[0][dsprd_pkg::LINE_CTL_DIV_BIT]
      |=> o_rdata_oe && o_rdata == $past(i_int_status[0]);
  endproperty
  a_isr_read: assert property (p_isr_read)
    else $error("interrupt status not returned");

  property p_prn_ctl_wr;
    s_ctl_wr
      |=> o_printer_control == $past(i_wdata);
  endproperty
  a_prn_ctl_wr: assert property (p_prn_ctl_wr)
    else $error("printer control not written");

  property p_prn_stat_rd;
    i_rd && !i_printer_select_n && i_chan_select_n == 2'b11
    && i_addr[1:0] == dsprd_pkg::PADDR_STAT_DIR
      |=> o_rdata_oe && o_rdata == $past(i_printer_status);
  endproperty
  a_prn_stat_rd: assert property (p_prn_stat_rd)
    else $error("printer status not returned");

  property p_dir_code_in;
    s_dir_wr(dsprd_pkg::DIR_CODE_INPUT)
      |=> i_bidirectional_enable_pin || !o_port_oe;
  endproperty
  a_dir_code_in: assert property (p_dir_code_in)
    else $error("input code did not turn the port inward");

  property p_dir_code_out;
    s_dir_wr(dsprd_pkg::DIR_CODE_OUTPUT)
      |=> i_bidirectional_enable_pin || o_port_oe;
  endproperty
  a_dir_code_out: assert property (p_dir_code_out)
    else $error("output code did not turn the port outward");

  property p_dir_ctl_bit;
    s_ctl_wr |=> !i_bidirectional_enable_pin
      || o_port_oe == !$past(i_wdata[dsprd_pkg::PRN_CTL_DIR_BIT]);
  endproperty
  a_dir_ctl_bit: assert property (p_dir_ctl_bit)
    else $error("control bit did not set port direction");

  property p_no_chan_keeps_lcr;
    i_chan_select_n == 2'b11
      |=> $stable(o_line_control);
  endproperty
  a_no_chan_keeps_lcr: assert property (p_no_chan_keeps_lcr)
    else $error("line control changed without channel select");

  property p_port_read_in;
    i_rd && !i_printer_select_n && i_chan_select_n == 2'b11
    && i_addr[1:0] == dsprd_pkg::PADDR_DATA && !o_port_oe
      |=> o_rdata == $past(i_port_in);
  endproperty
  a_port_read_in: assert property (p_port_read_in)
    else $error("inward port read did not return the pins");
endmodule // dsprd_top

// ==== dv/dsprd_host_model.sv ====
// Host processor model: drives the parallel register bus of the decode.
// Assumes the bench calls its task from one process at a time.
`timescale 1ns/1ps
module dsprd_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rdata_oe,
  output logic [2:0]      o_addr,
  output logic [7:0]      o_wdata,
  output logic            o_rd,
  output logic            o_wr,
  output logic [1:0]      o_chan_select_n,
  output logic            o_printer_select_n
);
  // Idle bus at time zero: no strobe, nothing selected
  initial begin
    o_addr             = 3'h0;
    o_wdata            = 8'h00;
    o_rd               = 1'b0;
    o_wr               = 1'b0;
    o_chan_select_n    = 2'h3;
    o_printer_select_n = 1'b1;
  end

  // One strobe per access, held until the taking edge, then released
  task automatic access(input logic wr, input logic [1:0] cs_n,
                        input logic ps_n, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic oe);
    @(posedge i_sys_clk);
    o_chan_select_n    <= cs_n;
    o_printer_select_n <= ps_n;
    o_addr             <= a;
    o_wdata            <= d;
    o_wr               <= wr;
    o_rd               <= ~wr;
    @(posedge i_sys_clk);
    o_wr               <= 1'b0;
    o_rd               <= 1'b0;
    o_chan_select_n    <= 2'h3;
    o_printer_select_n <= 1'b1;
    // Released lines flip so a stale value never looks valid
    o_addr             <= ~a;
    o_wdata            <= ~d;
    #1;
    q  = i_rdata;
    oe = i_rdata_oe;
  endtask
endmodule // dsprd_host_model

// ==== dv/dsprd_tb_top.sv ====
// Self-checking bench for the serial and printer register decode.
// Assumes the host model drives the bus; sideband inputs held by the bench.
`timescale 1ns/1ps
module dsprd_tb_top;
  localparam logic [1:0] CA = 2'h2;
  localparam logic [1:0] CB = 2'h1;
  localparam logic [1:0] NO = 2'h3;
  logic            i_sys_clk;
  logic            i_reset;
  logic [2:0]      i_addr;
  logic [7:0]      i_wdata;
  logic            i_rd;
  logic            i_wr;
  logic [1:0]      i_chan_select_n;
  logic            i_printer_select_n;
  logic [7:0]      o_rdata;
  logic            o_rdata_oe;
  logic [1:0][7:0] rx_in = {8'hb1, 8'ha1};
  logic [1:0][7:0] ist_in = {8'hb2, 8'ha2};
  logic [1:0][7:0] lst_in = {8'hb5, 8'ha5};
  logic [1:0][7:0] mst_in = {8'hb6, 8'ha6};
  logic [1:0][15:0] o_divisor;
  logic [1:0][7:0] o_line_control;
  logic [1:0][7:0] o_int_enable;
  logic [1:0][7:0] o_fifo_control;
  logic [1:0][7:0] o_modem_control;
  logic [1:0][7:0] o_tx_data;
  logic [1:0]      o_tx_load;
  logic [1:0]      o_rx_read;
  logic            pin = 1'b0;
  logic [7:0]      port_in = 8'h3c;
  logic [7:0]      pstat = 8'h7e;
  logic [7:0]      o_port_out;
  logic            o_port_oe;
  logic [7:0]      o_printer_control;
  logic [7:0]      txl_cnt = 8'h00;
  logic [7:0]      rxr_cnt = 8'h00;
  int              fail_count = 0;
  int              checked = 0;

  dsprd_top dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_rd(i_rd), .i_wr(i_wr),
    .i_chan_select_n(i_chan_select_n), .i_printer_select_n(i_printer_select_n),
    .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe), .i_rx_data(rx_in),
    .i_int_status(ist_in), .i_line_status(lst_in), .i_modem_status(mst_in),
    .o_divisor(o_divisor), .o_line_control(o_line_control),
    .o_int_enable(o_int_enable), .o_fifo_control(o_fifo_control),
    .o_modem_control(o_modem_control), .o_tx_data(o_tx_data),
    .o_tx_load(o_tx_load), .o_rx_read(o_rx_read),
    .i_bidirectional_enable_pin(pin), .i_port_in(port_in),
    .i_printer_status(pstat), .o_port_out(o_port_out), .o_port_oe(o_port_oe),
    .o_printer_control(o_printer_control));

  dsprd_host_model host (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata),
    .i_rdata_oe(o_rdata_oe), .o_addr(i_addr), .o_wdata(i_wdata), .o_rd(i_rd),
    .o_wr(i_wr), .o_chan_select_n(i_chan_select_n),
    .o_printer_select_n(i_printer_select_n));

  // 25 MHz system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Count the one-cycle side pulses of channel A at the edge they qualify
  always @(posedge i_sys_clk) begin
    if (o_tx_load[0] === 1'b1) txl_cnt <= txl_cnt + 8'h01;
    if (o_rx_read[0] === 1'b1) rxr_cnt <= rxr_cnt + 8'h01;
  end

  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk16(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  // Bus shorthands over the host model
  task automatic wr(input logic [1:0] c, input logic p, input logic [2:0] a,
                    input logic [7:0] d);
    logic [7:0] q;
    logic       oe;
    host.access(1'b1, c, p, a, d, q, oe);
  endtask
  task automatic rd(input logic [1:0] c, input logic p, input logic [2:0] a,
                    output logic [7:0] q, output logic oe);
    host.access(1'b0, c, p, a, 8'h00, q, oe);
  endtask

  task automatic t_reset;
    chk16("div_a", 16'h0000, o_divisor[0]);
    chk1("rdata_oe", 1'b0, o_rdata_oe);
    chk1("port_oe", 1'b1, o_port_oe);
    chk8("prn_ctl", 8'h00, o_printer_control);
  endtask

  task automatic t_divisor;
    logic [7:0] q;
    logic       oe;
    wr(CA, 1'b1, 3'h3, 8'h80);
    wr(CA, 1'b1, 3'h0, 8'h12);
    wr(CA, 1'b1, 3'h1, 8'h34);
    chk16("div_a", 16'h3412, o_divisor[0]);
    chk8("tx_a", 8'h00, o_tx_data[0]);
    chk8("ie_a", 8'h00, o_int_enable[0]);
    chk8("txl_cnt", 8'h00, txl_cnt);
    chk16("div_b", 16'h0000, o_divisor[1]);
    rd(CA, 1'b1, 3'h0, q, oe);
    chk8("rd_div_lo", 8'h12, q);
    chk1("rd_oe", 1'b1, oe);
    rd(CA, 1'b1, 3'h1, q, oe);
    chk8("rd_div_hi", 8'h34, q);
    @(posedge i_sys_clk);
    #1 chk1("oe_drop", 1'b0, o_rdata_oe);
  endtask

  task automatic t_general;
    logic [7:0] q;
    logic       oe;
    wr(CA, 1'b1, 3'h3, 8'h03);
    chk8("line_ctl_a", 8'h03, o_line_control[0]);
    wr(CA, 1'b1, 3'h0, 8'h5a);
    chk8("tx_a", 8'h5a, o_tx_data[0]);
    chk8("txl_cnt", 8'h01, txl_cnt);
    wr(CA, 1'b1, 3'h1, 8'h0f);
    chk8("ie_a", 8'h0f, o_int_enable[0]);
    chk16("div_a", 16'h3412, o_divisor[0]);
    rd(CA, 1'b1, 3'h0, q, oe);
    chk8("rx_a", 8'ha1, q);
    chk8("rxr_cnt", 8'h01, rxr_cnt);
    rd(CA, 1'b1, 3'h1, q, oe);
    chk8("int_stat_a", 8'ha2, q);
    rd(CA, 1'b1, 3'h5, q, oe);
    chk8("line_stat_a", 8'ha5, q);
    rd(CA, 1'b1, 3'h6, q, oe);
    chk8("modem_stat_a", 8'ha6, q);
    wr(CA, 1'b1, 3'h7, 8'he7);
    rd(CA, 1'b1, 3'h7, q, oe);
    chk8("scratch_a", 8'he7, q);
    wr(CA, 1'b1, 3'h2, 8'hc1);
    chk8("fifo_ctl_a", 8'hc1, o_fifo_control[0]);
    rd(CA, 1'b1, 3'h2, q, oe);
    chk8("int_stat_a2", 8'ha2, q);
    wr(CA, 1'b1, 3'h4, 8'h0b);
    chk8("modem_ctl_a", 8'h0b, o_modem_control[0]);
    rd(CA, 1'b1, 3'h4, q, oe);
    chk8("rd_modem_ctl_a", 8'h0b, q);
  endtask

  task automatic t_select;
    logic [7:0] q;
    logic       oe;
    wr(NO, 1'b1, 3'h3, 8'hff);
    chk8("line_ctl_a", 8'h03, o_line_control[0]);
    chk8("line_ctl_b", 8'h00, o_line_control[1]);
    rd(NO, 1'b1, 3'h0, q, oe);
    chk1("rd_oe", 1'b0, oe);
    wr(NO, 1'b1, 3'h2, 8'h20);
    chk8("prn_ctl", 8'h00, o_printer_control);
    wr(CB, 1'b1, 3'h3, 8'h80);
    wr(CB, 1'b1, 3'h0, 8'h99);
    chk16("div_b", 16'h0099, o_divisor[1]);
    chk16("div_a", 16'h3412, o_divisor[0]);
    rd(CB, 1'b1, 3'h1, q, oe);
    chk8("rd_div_hi_b", 8'h00, q);
    wr(CB, 1'b1, 3'h1, 8'h77);
    chk16("div_b_hi", 16'h7799, o_divisor[1]);
    chk8("tx_b", 8'h00, o_tx_data[1]);
  endtask

  task automatic t_printer;
    logic [7:0] q;
    logic       oe;
    rd(NO, 1'b0, 3'h1, q, oe);
    chk8("prn_stat", 8'h7e, q);
    wr(NO, 1'b0, 3'h0, 8'hc3);
    chk8("port_out", 8'hc3, o_port_out);
    wr(NO, 1'b0, 3'h1, 8'haa);
    chk1("port_oe", 1'b0, o_port_oe);
    rd(NO, 1'b0, 3'h0, q, oe);
    chk8("port_in", 8'h3c, q);
    wr(NO, 1'b0, 3'h5, 8'h55);
    chk1("port_oe", 1'b1, o_port_oe);
    rd(NO, 1'b0, 3'h4, q, oe);
    chk8("port_latch", 8'hc3, q);
    wr(NO, 1'b0, 3'h6, 8'h20);
    chk8("prn_ctl", 8'h20, o_printer_control);
    rd(NO, 1'b0, 3'h2, q, oe);
    chk8("prn_cmd", 8'h20, q);
    @(posedge i_sys_clk);
    pin <= 1'b1;
    @(posedge i_sys_clk);
    #1 chk1("port_oe", 1'b0, o_port_oe);
    wr(NO, 1'b0, 3'h1, 8'h55);
    chk1("port_oe", 1'b0, o_port_oe);
    wr(NO, 1'b0, 3'h2, 8'h00);
    chk1("port_oe", 1'b1, o_port_oe);
  endtask

  task automatic end_sim;
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn
  initial begin
    i_reset = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    #1 t_reset;
    t_divisor;
    t_general;
    t_select;
    t_printer;
    end_sim;
  end

  // Watchdog: the scenarios need well under a thousand cycles
  initial begin
    #(40 * 5000);
    fail_count++;
    end_sim;
  end
endmodule // dsprd_tb_top
